/* File: logic/led_regs_pkg.sv */
// Purpose: Constants and types for the LED driver config/status register bank
// Assumes: Byte-wide register port fed by a serial-bus front end
// Notes: Channel index 0 is blue, 1 green, 2 red, matching status bit order
//
// Contract
// - Current codes 8-bit, 0.1 mA steps, reset 0xaf
// - PWM select bit 6: 256 Hz or 558 Hz
// - Config bit 5 enables automatic power save
// - Bits 4:3 pick charge pump mode
// - Bit 2 routes red supply to battery
// - Bits 1:0 pick controller clock source
// - Three 4-bit program counters, reset zero
// - Program counter access only during hold
// - Status bit 3 shows external clock use
// - Status bits 2:0 are channel interrupt flags
// - Status read clears all channel flags
// - Active-low interrupt pin releases after status read
// - Writing 0xff to reset register resets all
// - Soft reset write gets no acknowledge
// - Output control bit 2 makes interrupt pin output
// - Bit 0 sets interrupt pin level as output
// - Execution code 00 means hold
package led_regs_pkg;

    localparam int NUM_CH = 3;
    localparam int PC_W = 4;
    localparam int CH_BLUE = 0;
    localparam int CH_GREEN = 1;
    localparam int CH_RED = 2;

    localparam logic [7:0] ADDR_GREEN_CURRENT = 8'h06;
    localparam logic [7:0] ADDR_BLUE_CURRENT = 8'h07;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_RED_PC = 8'h09;
    localparam logic [7:0] ADDR_GREEN_PC = 8'h0a;
    localparam logic [7:0] ADDR_BLUE_PC = 8'h0b;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h0d;
    localparam logic [7:0] ADDR_GPO_CTRL = 8'h0e;

    localparam logic [7:0] CURRENT_RESET = 8'haf;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] GPO_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 4'h0;
    localparam logic [NUM_CH-1:0] IRQ_NONE = 3'h0;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hff;

    typedef enum logic [1:0] {
        EXECUTION_CONTROL_HOLD = 2'b00,
        EXECUTION_CONTROL_STEP = 2'b01,
        EXECUTION_CONTROL_RUN = 2'b10,
        EXECUTION_CONTROL_ONCE = 2'b11
    } execution_control_t;

    typedef enum logic [1:0] {
        PUMP_OFF = 2'b00,
        PUMP_BYPASS_1X = 2'b01,
        PUMP_GAIN_1P5X = 2'b10,
        PUMP_AUTO = 2'b11
    } pump_mode_t;

    typedef enum logic [1:0] {
        CLK_SRC_EXTERNAL = 2'b00,
        CLK_SRC_INTERNAL = 2'b01,
        CLK_SRC_AUTO = 2'b10,
        CLK_SRC_INTERNAL_ALT = 2'b11
    } clk_src_t;

    typedef struct packed {
        logic reserved;
        logic pwm_clock_select;
        logic power_save_enable;
        pump_mode_t charge_pump_mode;
        logic red_supply_to_battery;
        clk_src_t clock_source;
    } config_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic external_clock_in_use;
        logic [NUM_CH-1:0] irq_flags;
    } status_t;

    typedef struct packed {
        logic [4:0] reserved;
        logic irq_pin_as_output;
        logic general_output_pin;
        logic irq_pin_level;
    } gpo_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* File: logic/channel_pc.sv */
// Purpose: One channel program counter with hold-gated host access
// Assumes: Engine loads only while not in hold
// Notes: Host write outside hold is dropped silently
`timescale 1ns/100ps
module channel_pc
    import led_regs_pkg::*;
#(
    parameter int W = PC_W
) (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic soft_clear, // Soft reset pulse
    input execution_control_t execution_control_mode, // Channel execution control
    input wire logic host_wr, // Host write to this counter
    input wire logic [W-1:0] host_wdata, // Host write value
    input wire logic engine_load, // Engine updates counter
    input wire logic [W-1:0] engine_value, // Engine counter value
    output logic in_hold, // Channel is in hold
    output logic [W-1:0] pc_value // Current counter
);

    typedef struct packed {
        logic [W-1:0] pc;
    } pc_state_t;

    pc_state_t state_ff;
    pc_state_t nxt_state;

    assign in_hold = (execution_control_mode == EXECUTION_CONTROL_HOLD);
    assign pc_value = state_ff.pc;

    always_comb begin
        nxt_state = state_ff;
        if (soft_clear) begin
            nxt_state.pc = W'(PC_RESET);
        end else if (host_wr && in_hold) begin
            nxt_state.pc = host_wdata;
        end else if (engine_load && !in_hold) begin
            nxt_state.pc = engine_value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff.pc <= W'(PC_RESET);
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule // channel_pc

/* File: logic/led_regs.sv */
// Purpose: Config, status, soft reset and output control registers
// Assumes: Bus front end gives one-cycle read/write strobes per byte
// Notes: Counter write spacing is left to the host
`timescale 1ns/100ps
module led_regs
    import led_regs_pkg::*;
(
    input wire logic clk, // Core clock, 125 MHz
    input wire logic rst_n, // Async reset, active low
    input reg_req_t bus_req, // Register request from bus front end
    output logic bus_ack, // Write acknowledge, same cycle
    output logic [7:0] bus_rdata, // Read data
    output logic bus_rvalid, // Read data valid pulse
    input execution_control_t [NUM_CH-1:0] execution_control, // Per-channel execution code
    input wire logic [NUM_CH-1:0] engine_pc_load, // Engine counter update
    input wire logic [NUM_CH-1:0][PC_W-1:0] engine_pc_value, // Engine counter values
    input wire logic [NUM_CH-1:0] channel_irq_event, // Channel interrupt pulses
    input wire logic external_clock_present, // Slow clock detector result
    input wire logic slow_pwm_tick, // 256 Hz tick from slow clock
    input wire logic fast_pwm_tick, // 558 Hz tick from oscillator
    output logic pwm_tick, // Selected PWM tick
    output logic [7:0] green_current_level, // Green current code
    output logic [7:0] blue_current_level, // Blue current code
    output logic pwm_clock_select, // PWM clock select
    output logic power_save_enable, // Power save enable
    output pump_mode_t charge_pump_mode, // Charge pump mode
    output logic red_supply_to_battery, // Red supply from battery
    output clk_src_t clock_source, // Controller clock source
    output logic external_clock_in_use, // External slow clock in use
    output logic [NUM_CH-1:0][PC_W-1:0] program_counter, // Counters to engines
    output logic irq_pin_out, // Interrupt pin level
    output logic irq_pin_oe, // Interrupt pin drive enable
    output logic general_output_pin // General output pin
);

    typedef struct packed {
        logic [7:0] green_cur;
        logic [7:0] blue_cur;
        config_t cfg;
        logic [NUM_CH-1:0] irq_flags;
        logic ext_in_use;
        gpo_ctrl_t general_output_control;
        logic [7:0] rdata;
        logic rvalid;
    } reg_state_t;

    localparam reg_state_t STATE_RESET = '{
        green_cur: CURRENT_RESET,
        blue_cur: CURRENT_RESET,
        cfg: config_t'(CONFIG_RESET),
        irq_flags: IRQ_NONE,
        ext_in_use: 1'b0,
        general_output_control: gpo_ctrl_t'(GPO_RESET),
        rdata: READ_ZERO,
        rvalid: 1'b0
    };

    reg_state_t state_ff;
    reg_state_t nxt_state;

    logic soft_reset_hit;
    logic addr_mapped;
    logic [NUM_CH-1:0] pc_wr;
    logic [NUM_CH-1:0] pc_hold;
    logic [NUM_CH-1:0] pc_rd_sel;
    logic [NUM_CH-1:0][PC_W-1:0] pc_val;

    assign soft_reset_hit = bus_req.wr && (bus_req.addr == ADDR_SOFT_RESET)
                            && (bus_req.wdata == SOFT_RESET_KEY);
    assign addr_mapped = (bus_req.addr >= ADDR_GREEN_CURRENT) && (bus_req.addr <= ADDR_GPO_CTRL);
    // Bank itself leaves the ack out for the reset key write
    assign bus_ack = bus_req.wr && addr_mapped && !soft_reset_hit;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_pc
            localparam logic [7:0] PC_ADDR = ADDR_BLUE_PC - 8'(ch);
            assign pc_wr[ch] = bus_req.wr && (bus_req.addr == PC_ADDR);
            assign pc_rd_sel[ch] = (bus_req.addr == PC_ADDR);
            channel_pc #(
                .W(PC_W)
            ) u_pc (
                .clk(clk),
                .rst_n(rst_n),
                .soft_clear(soft_reset_hit),
                .execution_control_mode(execution_control[ch]),
                .host_wr(pc_wr[ch]),
                .host_wdata(bus_req.wdata[PC_W-1:0]),
                .engine_load(engine_pc_load[ch]),
                .engine_value(engine_pc_value[ch]),
                .in_hold(pc_hold[ch]),
                .pc_value(pc_val[ch])
            );
        end
    endgenerate

    always_comb begin
        logic [7:0] rd_mux;
        logic [NUM_CH-1:0] flags_clr;
        status_t stat;
        rd_mux = READ_ZERO;
        flags_clr = IRQ_NONE;
        stat = '0;
        nxt_state = state_ff;

        // Clock in use follows the source field and the detector in auto
        case (state_ff.cfg.clock_source)
            CLK_SRC_EXTERNAL: nxt_state.ext_in_use = 1'b1;
            CLK_SRC_INTERNAL: nxt_state.ext_in_use = 1'b0;
            CLK_SRC_AUTO: nxt_state.ext_in_use = external_clock_present;
            CLK_SRC_INTERNAL_ALT: nxt_state.ext_in_use = 1'b0;
            default: nxt_state.ext_in_use = 1'b0;
        endcase

        stat.external_clock_in_use = state_ff.ext_in_use;
        stat.irq_flags = state_ff.irq_flags;

        case (bus_req.addr)
            ADDR_GREEN_CURRENT: rd_mux = state_ff.green_cur;
            ADDR_BLUE_CURRENT: rd_mux = state_ff.blue_cur;
            ADDR_CONFIG: rd_mux = state_ff.cfg;
            ADDR_RED_PC, ADDR_GREEN_PC, ADDR_BLUE_PC: rd_mux = READ_ZERO;
            ADDR_STATUS: rd_mux = stat;
            ADDR_GPO_CTRL: rd_mux = state_ff.general_output_control;
            default: rd_mux = READ_ZERO;
        endcase
        for (int i = 0; i < NUM_CH; i++) begin
            // Counter reads outside hold show zero; value may be in motion
            if (pc_rd_sel[i] && pc_hold[i]) begin
                rd_mux = {{(8-PC_W){1'b0}}, pc_val[i]};
            end
        end

        nxt_state.rvalid = bus_req.rd;
        if (bus_req.rd) begin
            nxt_state.rdata = rd_mux;
        end
        if (bus_req.rd && (bus_req.addr == ADDR_STATUS)) begin
            flags_clr = {NUM_CH{1'b1}};
        end
        // A new event in the clearing cycle survives
        nxt_state.irq_flags = (state_ff.irq_flags & ~flags_clr) | channel_irq_event;

        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_GREEN_CURRENT: nxt_state.green_cur = bus_req.wdata;
                ADDR_BLUE_CURRENT: nxt_state.blue_cur = bus_req.wdata;
                ADDR_CONFIG: begin
                    nxt_state.cfg = config_t'(bus_req.wdata);
                    nxt_state.cfg.reserved = 1'b0;
                end
                ADDR_GPO_CTRL: begin
                    nxt_state.general_output_control = gpo_ctrl_t'(bus_req.wdata);
                    nxt_state.general_output_control.reserved = '0;
                end
                default: nxt_state.cfg = state_ff.cfg;
            endcase
        end

        if (soft_reset_hit) begin
            nxt_state = STATE_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_rdata = state_ff.rdata;
    assign bus_rvalid = state_ff.rvalid;
    assign green_current_level = state_ff.green_cur;
    assign blue_current_level = state_ff.blue_cur;
    assign pwm_clock_select = state_ff.cfg.pwm_clock_select;
    assign pwm_tick = state_ff.cfg.pwm_clock_select ? fast_pwm_tick : slow_pwm_tick;
    assign power_save_enable = state_ff.cfg.power_save_enable;
    assign charge_pump_mode = state_ff.cfg.charge_pump_mode;
    assign red_supply_to_battery = state_ff.cfg.red_supply_to_battery;
    assign clock_source = state_ff.cfg.clock_source;
    assign external_clock_in_use = state_ff.ext_in_use;
    assign program_counter = pc_val;
    assign general_output_pin = state_ff.general_output_control.general_output_pin;

    // Interrupt use is open-drain low; output use drives both levels
    always_comb begin
        if (state_ff.general_output_control.irq_pin_as_output) begin
            irq_pin_out = state_ff.general_output_control.irq_pin_level;
            irq_pin_oe = 1'b1;
        end else begin
            irq_pin_out = 1'b0;
            irq_pin_oe = |state_ff.irq_flags;
        end
    end

endmodule // led_regs

/* File: tb/led_regs_sva.sv */
// Purpose: Port-level checks on the LED register bank
// Assumes: One clock domain, async active-low reset
// Notes: Attached to every bank instance by bind
`timescale 1ns/100ps
module led_regs_sva
    import led_regs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input reg_req_t bus_req, // Request
    input wire logic bus_ack, // Ack
    input wire logic [7:0] bus_rdata, // Read data
    input wire logic [NUM_CH-1:0] channel_irq_event, // Events
    input wire logic slow_pwm_tick, // Slow tick
    input wire logic fast_pwm_tick, // Fast tick
    input wire logic pwm_tick, // Chosen tick
    input wire logic pwm_clock_select, // Tick select
    input wire logic [7:0] green_current_level, // Green code
    input clk_src_t clock_source, // Source
    input wire logic external_clock_in_use, // In use
    input wire logic irq_pin_oe, // Pin enable
    input wire logic general_output_pin // Output pin
);
    logic sr_req;
    logic st_rd;
    logic clean_ff;
    assign sr_req = bus_req.wr && bus_req.addr == ADDR_SOFT_RESET && bus_req.wdata == SOFT_RESET_KEY;
    assign st_rd = bus_req.rd && bus_req.addr == ADDR_STATUS;
    // Status read seen and no event since
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) clean_ff <= 1'b0;
        else if (|channel_irq_event) clean_ff <= 1'b0;
        else if (st_rd) clean_ff <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_decode_a: assert property (bus_req.wr |-> bus_ack ==
        (bus_req.addr >= 8'h06 && bus_req.addr <= 8'h0e && !sr_req)) else $error("bad write ack");
    soft_reset_a: assert property (sr_req |=> green_current_level == 8'haf && !general_output_pin)
        else $error("soft reset missed");
    green_write_a: assert property (bus_req.wr && bus_req.addr == ADDR_GREEN_CURRENT
        |=> green_current_level == $past(bus_req.wdata)) else $error("green code not stored");
    pwm_select_a: assert property (pwm_tick == (pwm_clock_select ? fast_pwm_tick : slow_pwm_tick))
        else $error("wrong pwm tick");
    // Sampled reset keeps the release edge, where state is still reset, out
    ext_source_a: assert property (rst_n && clock_source == CLK_SRC_EXTERNAL && !sr_req
        |=> external_clock_in_use) else $error("external use not shown");
    int_source_a: assert property (clock_source inside {CLK_SRC_INTERNAL, CLK_SRC_INTERNAL_ALT}
        |=> !external_clock_in_use) else $error("internal source shown external");
    status_clear_a: assert property (st_rd && clean_ff && !(|channel_irq_event)
        |=> bus_rdata[2:0] == IRQ_NONE) else $error("flags not cleared");
    event_pin_a: assert property ((|channel_irq_event) && !sr_req |=> irq_pin_oe)
        else $error("pin not pulled");
    cover property (sr_req);
    cover property (st_rd && clean_ff);
    cover property (|channel_irq_event);
endmodule // led_regs_sva

bind led_regs led_regs_sva chk (.*);

/* File: tb/host_model.sv */
// Purpose: Host bus master model for the register bank
// Assumes: Requests launched on rising edges
// Notes: Counter writes spaced by PC_GAP cycles
`timescale 1ns/100ps
module host_model
    import led_regs_pkg::*;
#(
    parameter int PC_GAP = 19126
) (
    input wire logic clk, // Clock
    output reg_req_t req, // Request
    input wire logic ack, // Ack
    input wire logic [7:0] rdata, // Read data
    input wire logic rvalid // Read valid
);
    int cyc = 0;
    int last_pc = -PC_GAP;
    initial req = '0;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic write(input logic [7:0] a, input logic [7:0] v, output logic got);
        @(posedge clk);
        while (a inside {ADDR_RED_PC, ADDR_GREEN_PC, ADDR_BLUE_PC} && cyc - last_pc < PC_GAP) @(posedge clk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(posedge clk);
        // A missing ack is passed up, not retried
        got = ack;
        if (a inside {ADDR_RED_PC, ADDR_GREEN_PC, ADDR_BLUE_PC}) last_pc = cyc;
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] v, output logic got);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5a};
        @(posedge clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'ha5};
        @(posedge clk);
        got = rvalid;
        v = rdata;
    endtask
endmodule // host_model

/* File: tb/led_regs_tb.sv */
// Purpose: Self-checking bench for the LED register bank
// Assumes: Host model issues one request per call
// Notes: Counter write spacing dominates run length
`timescale 1ns/100ps
module led_regs_tb
    import led_regs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t bus_req;
    logic bus_ack, bus_rvalid, pwm_tick, pwm_clock_select, power_save_enable, red_supply_to_battery;
    logic external_clock_in_use, irq_pin_out, irq_pin_oe, general_output_pin, ok;
    logic [7:0] bus_rdata, green_current_level, blue_current_level, d;
    pump_mode_t charge_pump_mode;
    clk_src_t clock_source;
    logic [NUM_CH-1:0][PC_W-1:0] program_counter;
    execution_control_t [NUM_CH-1:0] execution_control = '{EXECUTION_CONTROL_HOLD, EXECUTION_CONTROL_HOLD, EXECUTION_CONTROL_HOLD};
    logic [NUM_CH-1:0] engine_pc_load = 3'h0;
    logic [NUM_CH-1:0] channel_irq_event = 3'h0;
    logic [NUM_CH-1:0][PC_W-1:0] engine_pc_value = 12'h090;
    logic external_clock_present = 1'b0;
    logic slow_pwm_tick = 1'b0;
    logic fast_pwm_tick = 1'b0;
    logic [7:0] rst_exp [11] = '{8'h00, 8'haf, 8'haf, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
    logic [7:0] v;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    led_regs uut (.*);
    host_model host (.clk(clk), .req(bus_req), .ack(bus_ack), .rdata(bus_rdata), .rvalid(bus_rvalid));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] x, input logic exp_ack);
        host.write(a, x, ok);
        chk({7'h0, ok}, {7'h0, exp_ack});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        host.read(a, d, ok);
        chk({7'h0, ok}, 8'h01);
        chk(d, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bound is about twice the counter write spacing
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rreg(8'h05 + 8'(i), rst_exp[i]);
        $display("test reset_values done");
        wreg(ADDR_GREEN_CURRENT, 8'h00, 1'b1);
        wreg(ADDR_BLUE_CURRENT, 8'hff, 1'b1);
        rreg(ADDR_GREEN_CURRENT, 8'h00);
        rreg(ADDR_BLUE_CURRENT, 8'hff);
        chk(blue_current_level, 8'hff);
        for (int m = 0; m < 8; m++) begin
            v = {1'b0, m[2], m[0], m[1:0], m[2], m[1:0]};
            external_clock_present <= m[2];
            fast_pwm_tick <= m[0];
            slow_pwm_tick <= ~m[0];
            wreg(ADDR_CONFIG, v, 1'b1);
            rreg(ADDR_CONFIG, v);
            rreg(ADDR_STATUS, {4'h0, m[1:0] == 2'b00 || (m[1:0] == 2'b10 && m[2]), 3'h0});
            chk({1'b0, pwm_clock_select, power_save_enable, charge_pump_mode, red_supply_to_battery, clock_source}, v);
            chk({7'h0, pwm_tick}, {7'h0, m[2] ? m[0] : ~m[0]});
        end
        $display("test config done");
        wreg(ADDR_RED_PC, 8'hf5, 1'b1);
        rreg(ADDR_RED_PC, 8'h05);
        chk({4'h0, program_counter[CH_RED]}, 8'h05);
        execution_control[CH_GREEN] <= EXECUTION_CONTROL_RUN;
        wreg(ADDR_GREEN_PC, 8'h03, 1'b1);
        chk({4'h0, program_counter[CH_GREEN]}, 8'h00);
        engine_pc_load[CH_GREEN] <= 1'b1;
        @(posedge clk);
        engine_pc_load[CH_GREEN] <= 1'b0;
        // Counter now holds 9, so a zero read shows the hold gate
        rreg(ADDR_GREEN_PC, 8'h00);
        chk({4'h0, program_counter[CH_GREEN]}, 8'h09);
        execution_control[CH_GREEN] <= EXECUTION_CONTROL_HOLD;
        rreg(ADDR_GREEN_PC, 8'h09);
        $display("test program_counter done");
        channel_irq_event <= 3'b101;
        @(posedge clk);
        channel_irq_event <= 3'h0;
        @(posedge clk);
        chk({6'h0, irq_pin_oe, irq_pin_out}, 8'h02);
        rreg(ADDR_STATUS, 8'h05);
        rreg(ADDR_STATUS, 8'h00);
        chk({7'h0, irq_pin_oe}, 8'h00);
        $display("test interrupt done");
        wreg(ADDR_GPO_CTRL, 8'hff, 1'b1);
        rreg(ADDR_GPO_CTRL, 8'h07);
        chk({5'h0, irq_pin_oe, irq_pin_out, general_output_pin}, 8'h07);
        wreg(ADDR_GPO_CTRL, 8'h04, 1'b1);
        rreg(ADDR_STATUS, 8'h00);
        chk({5'h0, irq_pin_oe, irq_pin_out, general_output_pin}, 8'h04);
        $display("test output_control done");
        wreg(ADDR_SOFT_RESET, 8'h5a, 1'b1);
        wreg(8'h0f, 8'h12, 1'b0);
        rreg(ADDR_GPO_CTRL, 8'h04);
        wreg(ADDR_SOFT_RESET, 8'hff, 1'b0);
        rreg(ADDR_GREEN_CURRENT, 8'haf);
        rreg(ADDR_GPO_CTRL, 8'h00);
        rreg(ADDR_CONFIG, 8'h00);
        chk({program_counter[CH_RED], program_counter[CH_GREEN]}, 8'h00);
        $display("test soft_reset done");
        wrap_up();
    end
endmodule // led_regs_tb
